/* hw/ecppl_top.sv */
// ecp parallel port: axi4-lite registers, shared fifo and link sequencer
`timescale 1ns/100ps
module ecppl_top #(
  parameter int DEPTH = ecppl_pkg::FIFO_DEPTH,
  parameter int THRESH = ecppl_pkg::FIFO_THRESH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // axi4-lite write
  input wire logic [ecppl_pkg::AW-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // axi4-lite read
  input wire logic [ecppl_pkg::AW-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // chip configuration
  input wire logic [2:0] cfg_irq_i,
  input wire logic [2:0] cfg_drq_i,
  // system requests
  output logic err_irq_o,
  output logic drq_o,
  // link pins
  input wire ecppl_pkg::ecppl_lnk_in_t lnk_i,
  output ecppl_pkg::ecppl_lnk_out_t lnk_o
);
  import ecppl_pkg::*;

  localparam int CW = $clog2(DEPTH) + 1;

  typedef enum logic [3:0] {
    L_IDLE, L_SETUP, L_STB, L_REL, L_TURN, L_RWAIT, L_RTAKE, L_RPT, L_BACK
  } ecppl_lst_t;

  function automatic logic [10:0] reg_idx(input logic [AW-1:0] a);
    return a[AW-1:2];
  endfunction

  function automatic logic reg_mapped(input logic [10:0] i);
    return (i == IDX_DATA) || (i == IDX_STAT) || (i == IDX_CTRL) ||
      (i == IDX_FIFO) || (i == IDX_CFGB) || (i == IDX_XCTL);
  endfunction

  ecppl_lnk_in_t sync_a;
  ecppl_lnk_in_t pin;
  ecppl_lst_t st;
  logic [7:0] data_latch;
  logic [5:0] dev_ctl;
  logic [2:0] mode;
  logic error_interrupt_enable_n;
  logic dma_request_enable;
  logic service_interrupt_flag;
  logic ecp_m, compat_fifo_port_m, test_m, cfg_m, dir_in;
  logic push_v, push_rdy, pop_v, pop_rdy;
  logic [8:0] push_d, pop_d, lnk_pd;
  logic [CW-1:0] f_cnt;
  logic aw_got, w_got, aw_take, w_take, wr_do, ar_take;
  logic [AW-1:0] wa;
  logic [7:0] wd, rd_mux, last_rd;
  logic wb0;
  logic [10:0] widx, ridx;
  logic bus_push, bus_pop, lnk_push, lnk_pop;
  logic fwd_go, rx_take, rx_cmd, rx_rle, svc_set;
  logic [3:0] stb_cnt;
  logic [6:0] rle_cnt, rpt_left;
  logic [7:0] rpt_byte;
  logic rle_pend;

  // pins are asynchronous; reset to idle levels so no false fault follows reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= '{pd: 8'h00, nack: 1'b1, busy: 1'b0, perror: 1'b1, select: 1'b1, nfault: 1'b1};
      pin <= '{pd: 8'h00, nack: 1'b1, busy: 1'b0, perror: 1'b1, select: 1'b1, nfault: 1'b1};
    end else begin
      sync_a <= lnk_i;
      pin <= sync_a;
    end
  end

  assign ecp_m = (mode == MODE_ECP);
  assign compat_fifo_port_m = (mode == MODE_COMPAT_FIFO_PORT);
  assign test_m = (mode == MODE_TEST);
  assign cfg_m = (mode == MODE_CFG);
  assign dir_in = dev_ctl[CTL_DIR] && (mode != MODE_SPP) && !compat_fifo_port_m;

  assign aw_take = awvalid_i && awready_o;
  assign w_take = wvalid_i && wready_o;
  assign wr_do = aw_got && w_got && !bvalid_o;
  assign ar_take = arvalid_i && arready_o;
  assign widx = reg_idx(wa);
  assign ridx = reg_idx(araddr_i);

  // write channel: address and data taken in either order
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
      wa <= '0;
      wd <= 8'h00;
      wb0 <= 1'b0;
    end else begin
      if (aw_take) begin
        wa <= awaddr_i;
      end
      if (w_take) begin
        wd <= wdata_i[7:0];
        wb0 <= wstrb_i[0];
      end
      aw_got <= !wr_do && (aw_got || aw_take);
      w_got <= !wr_do && (w_got || w_take);
      awready_o <= wr_do || !(aw_got || aw_take);
      wready_o <= wr_do || !(w_got || w_take);
      if (wr_do) begin
        bvalid_o <= 1'b1;
        bresp_o <= reg_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // software-written registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_latch <= DATA_RST;
      dev_ctl <= CTL_RST;
      mode <= XCTL_RST[XCTL_MODE+:3];
      error_interrupt_enable_n <= XCTL_RST[XCTL_NERR];
      dma_request_enable <= XCTL_RST[XCTL_DMA];
    end else if (wr_do && wb0) begin
      if (widx == IDX_DATA && (mode == MODE_SPP || mode == MODE_PS2)) begin
        data_latch <= wd;
      end else if (widx == IDX_CTRL) begin
        dev_ctl <= wd[5:0];
      end else if (widx == IDX_XCTL) begin
        mode <= wd[XCTL_MODE+:3];
        error_interrupt_enable_n <= wd[XCTL_NERR];
        dma_request_enable <= wd[XCTL_DMA];
      end
    end
  end

  // service flag: hardware set beats a software clear in the same cycle
  assign svc_set = !dma_request_enable && (ecp_m || compat_fifo_port_m || test_m) &&
    (dir_in ? (f_cnt >= CW'(THRESH)) : (f_cnt <= CW'(DEPTH - THRESH)));

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      service_interrupt_flag <= XCTL_RST[XCTL_SVC];
    end else if (svc_set) begin
      service_interrupt_flag <= 1'b1;
    end else if (wr_do && wb0 && widx == IDX_XCTL && wd[XCTL_SVC]) begin
      service_interrupt_flag <= 1'b0;
    end
  end

  // fifo traffic: bus fills forward, link fills reverse; if both push in one cycle, as a repeat run can, the link byte is taken
  assign bus_push = wr_do && wb0 &&
    ((widx == IDX_FIFO && (test_m || ((ecp_m || compat_fifo_port_m) && !dir_in))) ||
     (widx == IDX_DATA && ecp_m && !dir_in));
  assign bus_pop = ar_take && ridx == IDX_FIFO && pop_v && (test_m || (ecp_m && dir_in));
  assign push_v = lnk_push || bus_push;
  assign push_d = lnk_push ? lnk_pd : {widx == IDX_DATA, wd};
  assign pop_rdy = lnk_pop || bus_pop;

  // a write to a full fifo is dropped, as the test mode expects
  ecppl_fifo #(
    .W(9),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(push_v),
    .in_data_i(push_d),
    .in_ready_o(push_rdy),
    .out_valid_o(pop_v),
    .out_data_o(pop_d),
    .out_ready_i(pop_rdy),
    .count_o(f_cnt)
  );

  always_comb begin
    rd_mux = 8'h00;
    if (ridx == IDX_DATA) begin
      rd_mux = (mode == MODE_SPP || mode == MODE_PS2) ? pin.pd : 8'h00;
    end else if (ridx == IDX_STAT) begin
      rd_mux = {!pin.busy, pin.nack, pin.perror, pin.select, pin.nfault, 3'h0};
    end else if (ridx == IDX_CTRL) begin
      rd_mux = {2'h0, dev_ctl};
    end else if (ridx == IDX_FIFO) begin
      // empty test fifo re-reads the last byte
      rd_mux = cfg_m ? CFGA_VAL : (pop_v ? pop_d[7:0] : last_rd);
    end else if (ridx == IDX_CFGB && cfg_m) begin
      // no compressor fitted, so the compress bit reads zero
      rd_mux = {1'b0, err_irq_o, cfg_irq_i, cfg_drq_i};
    end else if (ridx == IDX_XCTL) begin
      rd_mux = {mode, error_interrupt_enable_n, dma_request_enable,
        service_interrupt_flag, !push_rdy, !pop_v};
    end
  end

  // read channel: data registered at the taking edge
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= RESP_OKAY;
    end else if (ar_take) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b1;
      rdata_o <= {24'h00_0000, rd_mux};
      rresp_o <= reg_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
      arready_o <= 1'b1;
    end else if (!rvalid_o) begin
      arready_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_irq_o <= 1'b0;
      drq_o <= 1'b0;
      last_rd <= 8'h00;
    end else begin
      err_irq_o <= !pin.nfault && !dir_in && !error_interrupt_enable_n;
      drq_o <= dma_request_enable && (ecp_m || compat_fifo_port_m || test_m) &&
        (dir_in ? pop_v : push_rdy);
      if (bus_pop) begin
        last_rd <= pop_d[7:0];
      end
    end
  end

  // link sequencer helpers
  assign fwd_go = st == L_IDLE && (ecp_m || compat_fifo_port_m) && !dir_in && pop_v &&
    !pin.busy && (compat_fifo_port_m || pin.perror);
  assign rx_take = st == L_RWAIT && ecp_m && dir_in && !pin.nack && push_rdy;
  assign rx_cmd = !pin.busy;
  assign rx_rle = rx_cmd && !pin.pd[7];
  assign lnk_pop = fwd_go;
  assign lnk_push = (rx_take && !rx_rle) || (st == L_RPT && push_rdy);
  assign lnk_pd = (st == L_RPT) ? {1'b0, rpt_byte} : {rx_cmd, pin.pd};

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= L_IDLE;
      lnk_o <= LNK_IDLE;
      stb_cnt <= 4'h0;
      rle_cnt <= 7'h00;
      rle_pend <= 1'b0;
      rpt_left <= 7'h00;
      rpt_byte <= 8'h00;
    end else if (!ecp_m && !compat_fifo_port_m) begin
      // plain modes: pins follow the control register
      st <= L_IDLE;
      rle_pend <= 1'b0;
      rpt_left <= 7'h00;
      lnk_o.pd <= test_m ? last_rd : data_latch;
      lnk_o.pd_oe <= !dir_in;
      lnk_o.nstrobe <= !dev_ctl[CTL_STB];
      lnk_o.nautofd <= !dev_ctl[CTL_AFD];
      lnk_o.ninit <= dev_ctl[CTL_INIT];
      lnk_o.nselectin <= !dev_ctl[CTL_SELIN];
    end else begin
      lnk_o.nselectin <= ecp_m || !dev_ctl[CTL_SELIN];
      if (compat_fifo_port_m) begin
        lnk_o.nautofd <= !dev_ctl[CTL_AFD];
        lnk_o.ninit <= dev_ctl[CTL_INIT];
      end
      case (st)
        L_IDLE: begin
          if (ecp_m && dir_in) begin
            lnk_o.pd_oe <= 1'b0;
            lnk_o.ninit <= 1'b0;
            st <= L_TURN;
          end else if (fwd_go) begin
            lnk_o.pd <= pop_d[7:0];
            lnk_o.pd_oe <= 1'b1;
            if (ecp_m) begin
              lnk_o.nautofd <= !pop_d[8];
            end
            st <= L_SETUP;
          end else begin
            lnk_o.pd_oe <= compat_fifo_port_m || pin.perror;
            if (ecp_m) begin
              lnk_o.ninit <= 1'b1;
            end
          end
        end
        L_SETUP: begin
          // data has stood one cycle before the strobe falls
          lnk_o.nstrobe <= 1'b0;
          stb_cnt <= 4'(STB_CYC);
          st <= L_STB;
        end
        L_STB: begin
          if (ecp_m ? pin.busy : (stb_cnt == 4'h1)) begin
            lnk_o.nstrobe <= 1'b1;
            stb_cnt <= 4'(STB_CYC);
            st <= L_REL;
          end else if (stb_cnt != 4'h1) begin
            stb_cnt <= stb_cnt - 4'h1;
          end
        end
        L_REL: begin
          // hold off so the synchronised busy has caught up
          if (stb_cnt != 4'h1) begin
            stb_cnt <= stb_cnt - 4'h1;
          end else if (!pin.busy) begin
            st <= L_IDLE;
          end
        end
        L_TURN: begin
          if (!dir_in) begin
            lnk_o.ninit <= 1'b1;
            st <= L_BACK;
          end else if (!pin.perror) begin
            lnk_o.nautofd <= 1'b0;
            st <= L_RWAIT;
          end
        end
        L_RWAIT: begin
          if (!dir_in) begin
            lnk_o.ninit <= 1'b1;
            lnk_o.nautofd <= 1'b1;
            st <= L_BACK;
          end else if (rx_take) begin
            lnk_o.nautofd <= 1'b1;
            if (rx_rle) begin
              rle_cnt <= pin.pd[6:0];
              rle_pend <= 1'b1;
            end else if (!rx_cmd && rle_pend) begin
              rpt_left <= rle_cnt;
              rpt_byte <= pin.pd;
              rle_pend <= 1'b0;
            end
            st <= L_RTAKE;
          end
        end
        L_RTAKE: begin
          if (pin.nack) begin
            if (rpt_left != 7'h00) begin
              st <= L_RPT;
            end else begin
              lnk_o.nautofd <= 1'b0;
              st <= L_RWAIT;
            end
          end
        end
        L_RPT: begin
          // a full fifo stalls the run, holding hostack high
          if (push_rdy) begin
            rpt_left <= rpt_left - 7'h01;
            if (rpt_left == 7'h01) begin
              lnk_o.nautofd <= 1'b0;
              st <= L_RWAIT;
            end
          end
        end
        L_BACK: begin
          if (pin.perror) begin
            st <= L_IDLE;
          end
        end
        default: begin
          st <= L_IDLE;
        end
      endcase
    end
  end

  default clocking ecppl_cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  ecp_selin_a: assert property (ecp_m && $past(ecp_m) |-> lnk_o.nselectin)
    else $error("selectin asserted in ecp mode");
  drive_permit_a: assert property (ecp_m && $rose(lnk_o.pd_oe) |-> $past(pin.perror))
    else $error("data driven without perror permission");
  strobe_data_a: assert property (st == L_STB |-> lnk_o.pd_oe && !lnk_o.nstrobe)
    else $error("strobe low without data driven");
  strobe_hold_a: assert property (st == L_STB && ecp_m && !pin.busy |=> !lnk_o.nstrobe)
    else $error("strobe released before busy");
  rle_skip_a: assert property (rx_take && rx_rle |-> !push_v)
    else $error("run-length byte stored");
  rle_run_a: assert property (st == L_RPT && push_rdy && rpt_left == 7'h01 |=>
    st == L_RWAIT && !lnk_o.nautofd)
    else $error("run not closed");
  full_flag_a: assert property (ar_take && ridx == IDX_XCTL |=>
    rdata_o[XCTL_FULL] == $past(f_cnt == CW'(DEPTH)) && rdata_o[XCTL_EMPTY] == $past(f_cnt == '0))
    else $error("fifo flags wrong");
  fault_irq_a: assert property (!pin.nfault && !dir_in && !error_interrupt_enable_n
    |=> err_irq_o)
    else $error("error interrupt missing");
  rev_init_a: assert property (st == L_RWAIT || st == L_RTAKE |-> !lnk_o.ninit)
    else $error("init high during reverse");
  hostack_rel_a: assert property (st == L_RTAKE && $rose(lnk_o.nautofd) |->
    $past(!pin.nack, 1))
    else $error("hostack released without peripheral ack");
  fwd_tag_a: assert property (fwd_go && ecp_m |=> lnk_o.nautofd == !$past(pop_d[8]))
    else $error("forward tag wrong");
endmodule

/* hw/ecppl_pkg.sv */
// constants, register map and link carriers of the ecp parallel port block
package ecppl_pkg;
  localparam int AW = 13;
  localparam int PWORD = 8;
  // printed register indexes, byte address is index times four
  localparam logic [10:0] IDX_DATA = 11'h000;
  localparam logic [10:0] IDX_STAT = 11'h001;
  localparam logic [10:0] IDX_CTRL = 11'h002;
  localparam logic [10:0] IDX_FIFO = 11'h400;
  localparam logic [10:0] IDX_CFGB = 11'h401;
  localparam logic [10:0] IDX_XCTL = 11'h402;
  // operating modes
  localparam logic [2:0] MODE_SPP = 3'h0;
  localparam logic [2:0] MODE_PS2 = 3'h1;
  localparam logic [2:0] MODE_COMPAT_FIFO_PORT = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG = 3'h7;
  // device control fields
  localparam int CTL_STB = 0;
  localparam int CTL_AFD = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int CTL_ACKIE = 4;
  localparam int CTL_DIR = 5;
  // extended control fields
  localparam int XCTL_MODE = 5;
  localparam int XCTL_NERR = 4;
  localparam int XCTL_DMA = 3;
  localparam int XCTL_SVC = 2;
  localparam int XCTL_FULL = 1;
  localparam int XCTL_EMPTY = 0;
  // reset values and fixed read-back
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [5:0] CTL_RST = 6'h00;
  localparam logic [7:0] XCTL_RST = 8'h00;
  localparam logic [7:0] CFGA_VAL = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // fifo and timing
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_THRESH = 8;
  localparam int CLK_MHZ = 10;
  localparam int STB_NS = 500;
  localparam int STB_CYC = (STB_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [7:0] pd;
    logic nack;
    logic busy;
    logic perror;
    logic select;
    logic nfault;
  } ecppl_lnk_in_t;

  typedef struct packed {
    logic [7:0] pd;
    logic pd_oe;
    logic nstrobe;
    logic nautofd;
    logic ninit;
    logic nselectin;
  } ecppl_lnk_out_t;

  localparam ecppl_lnk_out_t LNK_IDLE = '{pd: 8'h00, pd_oe: 1'b0, nstrobe: 1'b1,
    nautofd: 1'b1, ninit: 1'b1, nselectin: 1'b1};
endpackage

/* hw/ecppl_fifo.sv */
// shared byte fifo with valid/ready on both sides
`timescale 1ns/100ps
module ecppl_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i,
  // occupancy
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic push;
  logic pop;

  assign in_ready_o = (count_o != (PW+1)'(DEPTH));
  assign out_valid_o = (count_o != '0);
  assign out_data_o = mem[rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp <= '0;
      rp <= '0;
      count_o <= '0;
    end else begin
      if (push) begin
        wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      if (push && !pop) begin
        count_o <= count_o + 1'b1;
      end else if (pop && !push) begin
        count_o <= count_o - 1'b1;
      end
    end
  end
endmodule

/* dv/ecppl_periph.sv */
// behavioural ecp peripheral on the far side of the link pins
`timescale 1ns/100ps
module ecppl_periph
  import ecppl_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // link pins and fault request
  input wire ecppl_pkg::ecppl_lnk_out_t lnk_o_i,
  input wire logic fault_n_i,
  output ecppl_pkg::ecppl_lnk_in_t lnk_i_o
);
  logic [8:0] rev_q[$];
  logic [8:0] fwd_q[$];
  logic busy = 1'b0, nack = 1'b1, perr = 1'b1, drv = 1'b0, ph = 1'b0;
  logic [7:0] pdv = 8'h00;
  int clash = 0;
  // released bus shows the inverse of our last byte, never a stale copy
  assign lnk_i_o = '{pd: drv ? pdv : (lnk_o_i.pd_oe ? lnk_o_i.pd : ~pdv), nack: nack,
    busy: busy, perror: perr, select: 1'b1, nfault: fault_n_i};
  always @(posedge sys_clk_i) begin
    perr <= lnk_o_i.ninit;
    if (drv && lnk_o_i.pd_oe) clash <= clash + 1;
    if (lnk_o_i.ninit) begin
      if (!lnk_o_i.nstrobe && !busy) begin
        fwd_q.push_back({lnk_o_i.nautofd, lnk_o_i.pd});
        busy <= 1'b1;
      end else if (lnk_o_i.nstrobe && busy) busy <= 1'b0;
    end else if (!ph && !drv && !perr && !lnk_o_i.nautofd && rev_q.size() > 0) begin
      {busy, pdv} <= rev_q.pop_front();
      drv <= 1'b1;
    end else if (drv && !ph) begin
      nack <= 1'b0;
      ph <= 1'b1;
    end else if (ph && lnk_o_i.nautofd) begin
      nack <= 1'b1;
      drv <= 1'b0;
      ph <= 1'b0;
    end
  end
endmodule

/* dv/ecppl_top_tb.sv */
// self-checking bench for the ecp parallel port block
`timescale 1ns/100ps
module ecppl_top_tb;
  import ecppl_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, fault_n = 1'b1;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, err_irq, drq;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] cfg_irq = 3'h5, cfg_drq = 3'h2;
  logic [7:0] b[16];
  logic [7:0] e[6];
  ecppl_lnk_in_t lnk_in;
  ecppl_lnk_out_t lnk_out;
  int bad_count = 0, samples_checked = 0;
  always #50 sys_clk = ~sys_clk;
  ecppl_top #(.DEPTH(16), .THRESH(8)) i_ecppl_top (.sys_clk_i(sys_clk), .nrst_i(nrst),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
    .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
    .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
    .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
    .rready_i(rready), .cfg_irq_i(cfg_irq), .cfg_drq_i(cfg_drq), .err_irq_o(err_irq),
    .drq_o(drq), .lnk_i(lnk_in), .lnk_o(lnk_out));
  ecppl_periph i_ecppl_periph (.sys_clk_i(sys_clk), .lnk_o_i(lnk_out),
    .fault_n_i(fault_n), .lnk_i_o(lnk_in));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [10:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [10:0] i);
    @(posedge sys_clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_fwd(input int n);
    for (int k = 0; k < 600 && i_ecppl_periph.fwd_q.size() < n; k++) @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(74081));
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(32'(err_irq), 32'h0);
    @(posedge sys_clk);
    chk(32'(lnk_out.nstrobe & lnk_out.nselectin & lnk_out.nautofd), 32'h1);
    rdr(IDX_CTRL); chk(rd, 32'h0);
    rdr(IDX_XCTL); chk(rd, 32'h01);
    rdr(11'h005); chk(32'(rs), 32'(RESP_SLVERR));
    wr(11'h005, 8'hff); chk(32'(rs), 32'(RESP_SLVERR));
    // bidirectional mode, forward: latch drives the lines and reads back through the pins
    wr(IDX_XCTL, 8'h20); chk(32'(rs), 32'(RESP_OKAY));
    wr(IDX_DATA, 8'ha5);
    repeat (2) @(posedge sys_clk);
    rdr(IDX_DATA); chk(rd, 32'ha5);
    chk(32'(lnk_out.pd), 32'ha5);
    fault_n <= 1'b0;
    cfg_irq <= 3'($urandom);
    cfg_drq <= 3'($urandom);
    repeat (6) @(posedge sys_clk);
    chk(32'(err_irq), 32'h1);
    rdr(IDX_STAT); chk(rd, 32'hd0);
    fault_n <= 1'b1;
    wr(IDX_XCTL, 8'he0);
    rdr(IDX_CFGB); chk(rd, {26'h0, cfg_irq, cfg_drq});
    rdr(IDX_FIFO); chk(rd, 32'(CFGA_VAL));
    rdr(IDX_CTRL); chk(rd, 32'h0);
    wr(IDX_XCTL, 8'hc0);
    for (int i = 0; i < 16; i++) begin
      b[i] = 8'($urandom);
      wr(IDX_FIFO, b[i]);
    end
    rdr(IDX_XCTL); chk(rd & 32'h3, 32'h2);
    wr(IDX_FIFO, 8'h5a);
    for (int i = 0; i < 16; i++) begin
      rdr(IDX_FIFO); chk(rd, 32'(b[i]));
    end
    rdr(IDX_XCTL); chk(rd & 32'h3, 32'h1);
    rdr(IDX_FIFO); chk(rd, 32'(b[15]));
    i_ecppl_periph.fwd_q.delete();
    wr(IDX_XCTL, 8'h68);
    wr(IDX_DATA, b[7]);
    for (int i = 0; i < 3; i++) wr(IDX_FIFO, b[i]);
    chk(32'(drq), 32'h1);
    wait_fwd(4);
    chk(32'(i_ecppl_periph.fwd_q[0]), {24'h0, b[7]});
    for (int i = 0; i < 3; i++) chk(32'(i_ecppl_periph.fwd_q[i + 1]), {23'h0, 1'b1, b[i]});
    chk(32'(lnk_out.nselectin), 32'h1);
    // run count 3 gives four copies, high bit marks a stored command
    e = '{b[3], b[4], b[4], b[4], b[4], 8'h85};
    i_ecppl_periph.rev_q = '{{1'b1, b[3]}, 9'h003, {1'b1, b[4]}, 9'h085};
    wr(IDX_CTRL, 8'h20);
    fault_n <= 1'b0;
    for (int k = 0; k < 900 && (i_ecppl_periph.rev_q.size() > 0 || i_ecppl_periph.drv); k++)
      @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    chk(32'(lnk_out.ninit), 32'h0);
    chk(32'(err_irq), 32'h0);
    for (int i = 0; i < 6; i++) begin
      rdr(IDX_FIFO); chk(rd, 32'(e[i]));
    end
    rdr(IDX_XCTL); chk(rd & 32'h1, 32'h1);
    chk(32'(i_ecppl_periph.clash), 32'h0);
    wr(IDX_CTRL, 8'h24);
    fault_n <= 1'b1;
    wr(IDX_XCTL, 8'h40);
    i_ecppl_periph.fwd_q.delete();
    wr(IDX_FIFO, b[5]);
    wait_fwd(1);
    chk(32'(i_ecppl_periph.fwd_q.size()), 32'h1);
    chk(32'(i_ecppl_periph.fwd_q[0][7:0]), 32'(b[5]));
    // reset in mid transfer with bytes still queued
    for (int i = 0; i < 3; i++) wr(IDX_FIFO, b[i]);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(32'(lnk_out), 32'(LNK_IDLE));
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(32'(err_irq), 32'h0);
    rdr(IDX_XCTL); chk(rd, 32'h01);
    rdr(IDX_CTRL); chk(rd, 32'h0);
    report_and_stop();
  end
endmodule
